// ### anpg_page_regs.sv
/*
  Negotiation page registers: partner ability (base and next page
  views), expansion with latched flags, and the outgoing next page with
  device-maintained acknowledge and sync bits.
  Assumes a management port that offers one read or write per cycle and
  an arbitration engine that pulses on each received page and on each
  outgoing page it takes. All inputs except rst_in are synchronous to core_clk_in.
*/
// Functional notes
// - Base bit 15: partner wants next pages.
// - Base bit 14: partner received consistent bursts.
// - Base bit 13: partner signals a fault.
// - Base bits 12:5: partner capability bits.
// - Base bits 4:0: partner selector, 00001 standard.
// - Next bit 15: more pages follow.
// - Next bit 14: partner received our word.
// - Next bit 13: message versus unformatted page.
// - Next bit 12: partner can comply.
// - Next bit 11: partner sync bit.
// - Bits 10:0 carry eleven-bit page code.
// - Expansion bit 4 latches; read clears it.
// - Expansion bit 3: partner supports next pages.
// - Expansion bit 2 always reads one.
// - Expansion bit 1 latches on page received.
// - Expansion bit 0: partner can negotiate.
// - Outgoing bit 14 mirrors acknowledge, read-only.
// - Outgoing sync bit inverts each exchanged page.
// - First sync bit inverts base word bit 11.
// - Bits 8..5: TX full, TX, T full, T.
`default_nettype none

module anpg_page_regs
(
  input  wire logic        core_clk_in,           // Core clock, 25 MHz.
  input  wire logic        rst_in,                // Asynchronous reset, active high.
  input  wire logic [4:0]  mgmt_addr_in,          // Management register number.
  input  wire logic        mgmt_rd_in,            // Read strobe, one cycle.
  input  wire logic        mgmt_wr_in,            // Write strobe, one cycle.
  input  wire logic [15:0] mgmt_wdata_in,         // Write data.
  output logic      [15:0] mgmt_rdata_out,        // Read data.
  output logic             mgmt_rvalid_out,       // Read data valid, one cycle.
  input  wire logic        an_restart_in,         // Negotiation restarted, pulse.
  input  wire logic        rx_page_valid_in,      // Page received, pulse.
  input  wire logic [15:0] rx_code_word_in,       // Received link code word.
  input  wire logic        parallel_detect_error_in, // Concurrent link detect, pulse.
  input  wire logic        partner_negotiation_capable_in, // Partner can negotiate.
  input  wire logic        local_base_sync_in,    // Bit 11 of our base code word.
  input  wire logic        tx_ack_in,             // Acknowledge bit of our code word.
  input  wire logic        tx_page_taken_in,      // Outgoing page sent, pulse.
  output logic      [15:0] tx_code_word_out,      // Outgoing next page word.
  output logic             tx_page_ready_out      // New outgoing page written.
);

  logic        base_done_q;
  logic        view_next_q;
  logic        par_fault_q;
  logic        page_rx_q;
  logic        lp_np_able_q;
  logic        sync_q;
  logic [15:0] out_page_q;
  logic        rd_pend_q;
  logic [4:0]  rd_addr_q;
  logic [15:0] exp_snap_q;
  logic [15:0] exp_word;
  logic [15:0] store_rdata;
  logic        rd_exp;
  logic        store_wr_idx;

  assign rd_exp       = mgmt_rd_in && (mgmt_addr_in == anpg_pkg::REG_EXPANSION);
  assign store_wr_idx = base_done_q;

  ////////////////////////////////////////////////////////////////////////
  // Received pages. The word is kept whole, so every base field (more
  // pages, receipt, fault, capability bits 12..5, selector) and every next
  // page field (sync bit, code) reads back in its received position.
  anpg_page_store u_store
  (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .wr_en_in    (rx_page_valid_in),
    .wr_idx_in   (store_wr_idx),
    .wr_data_in  (rx_code_word_in),
    .rd_idx_in   (view_next_q),
    .rd_data_out (store_rdata)
  );

  // The first page after a restart is the base page; every later one is a
  // next page. The view switches only once a next page exists, so software
  // never sees an empty next page layout.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      base_done_q <= 1'b0;
      view_next_q <= 1'b0;
    end
    else if (an_restart_in)
    begin
      base_done_q <= 1'b0;
      view_next_q <= 1'b0;
    end
    else if (rx_page_valid_in)
    begin
      base_done_q <= 1'b1;
      view_next_q <= base_done_q;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lp_np_able_q <= 1'b0;
    end
    else if (an_restart_in)
    begin
      lp_np_able_q <= 1'b0;
    end
    else if (rx_page_valid_in && !base_done_q)
    begin
      lp_np_able_q <= rx_code_word_in[anpg_pkg::BP_MORE_PAGES];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Latched expansion flags. An event in the cycle of the clearing read
  // wins, so it is reported by the next read rather than lost.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      par_fault_q <= 1'b0;
    end
    else if (parallel_detect_error_in)
    begin
      par_fault_q <= 1'b1;
    end
    else if (rd_exp)
    begin
      par_fault_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      page_rx_q <= 1'b0;
    end
    else if (rx_page_valid_in)
    begin
      page_rx_q <= 1'b1;
    end
    else if (rd_exp)
    begin
      page_rx_q <= 1'b0;
    end
  end

  always_comb
  begin
    exp_word                           = 16'h0000;
    exp_word[anpg_pkg::EXP_PAR_FAULT]  = par_fault_q;
    exp_word[anpg_pkg::EXP_LP_NP_ABLE] = lp_np_able_q;
    exp_word[anpg_pkg::EXP_NP_ABLE]    = 1'b1;
    exp_word[anpg_pkg::EXP_PAGE_RX]    = page_rx_q;
    exp_word[anpg_pkg::EXP_LP_ANEG]    = partner_negotiation_capable_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outgoing page. Software owns bits 15, 13, 12 and the code field; the
  // acknowledge and sync bits are the device's and ignore writes.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      out_page_q <= anpg_pkg::OUT_PAGE_RESET;
    end
    else if (mgmt_wr_in && (mgmt_addr_in == anpg_pkg::REG_OUTGOING_PAGE))
    begin
      out_page_q <= mgmt_wdata_in & anpg_pkg::OUT_WRITABLE_MASK;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync_q <= anpg_pkg::SYNC_RESET;
    end
    else if (an_restart_in)
    begin
      sync_q <= anpg_pkg::SYNC_RESET;
    end
    else if (rx_page_valid_in && !base_done_q)
    begin
      sync_q <= ~local_base_sync_in;
    end
    else if (tx_page_taken_in && base_done_q)
    begin
      sync_q <= ~sync_q;
    end
  end

  // A write and a take in the same cycle leave the page pending, since
  // the word just written has not been sent yet.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_page_ready_out <= 1'b0;
    end
    else if (mgmt_wr_in && (mgmt_addr_in == anpg_pkg::REG_OUTGOING_PAGE))
    begin
      tx_page_ready_out <= 1'b1;
    end
    else if (tx_page_taken_in)
    begin
      tx_page_ready_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_code_word_out <= anpg_pkg::OUT_PAGE_RESET;
    end
    else
    begin
      tx_code_word_out                       <= out_page_q;
      tx_code_word_out[anpg_pkg::NP_ACK]     <= tx_ack_in;
      tx_code_word_out[anpg_pkg::NP_SYNC]    <= sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Management reads take two cycles: the store and the expansion flags
  // are sampled at the strobe, then the answer is registered.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_pend_q  <= 1'b0;
      rd_addr_q  <= 5'h00;
      exp_snap_q <= 16'h0000;
    end
    else
    begin
      rd_pend_q  <= mgmt_rd_in;
      rd_addr_q  <= mgmt_addr_in;
      exp_snap_q <= exp_word;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mgmt_rdata_out  <= 16'h0000;
      mgmt_rvalid_out <= 1'b0;
    end
    else
    begin
      mgmt_rvalid_out <= rd_pend_q;
      if (!rd_pend_q)
      begin
        mgmt_rdata_out <= 16'h0000;
      end
      else
      begin
        case (rd_addr_q)
          anpg_pkg::REG_PARTNER_ABILITY: mgmt_rdata_out <= store_rdata;
          anpg_pkg::REG_EXPANSION:       mgmt_rdata_out <= exp_snap_q;
          anpg_pkg::REG_OUTGOING_PAGE:   mgmt_rdata_out <= tx_code_word_out;
          default:                       mgmt_rdata_out <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  AST_NP_ABLE_ONE: assert property (
    mgmt_rd_in && mgmt_addr_in == anpg_pkg::REG_EXPANSION
      |-> ##2 mgmt_rvalid_out && mgmt_rdata_out[anpg_pkg::EXP_NP_ABLE])
    else $error("expansion next page able bit not one");

  AST_PAR_FAULT_SET: assert property (
    parallel_detect_error_in |=> par_fault_q)
    else $error("parallel detect fault not latched");

  AST_PAR_FAULT_HOLD: assert property (
    par_fault_q && !rd_exp |=> par_fault_q)
    else $error("parallel detect fault cleared without read");

  AST_PAGE_RX_SET: assert property (
    rx_page_valid_in |=> page_rx_q ##1 (page_rx_q || $past(rd_exp)))
    else $error("page received flag not latched");

  AST_VIEW_SWITCH: assert property (
    rx_page_valid_in && !an_restart_in |=> base_done_q && (view_next_q == $past(base_done_q)))
    else $error("partner ability view wrong after page");

  AST_FIRST_SYNC: assert property (
    (rx_page_valid_in && !base_done_q && !an_restart_in) ##1 (!an_restart_in && !tx_page_taken_in)
      |=> tx_code_word_out[anpg_pkg::NP_SYNC] == !$past(local_base_sync_in, 2))
    else $error("first sync bit not inverse of base word");

  AST_SYNC_FLIP: assert property (
    tx_page_taken_in && base_done_q && !an_restart_in
      |-> ##2 tx_code_word_out[anpg_pkg::NP_SYNC] != $past(tx_code_word_out[anpg_pkg::NP_SYNC]))
    else $error("sync bit did not invert after exchange");

  AST_ACK_MIRROR: assert property (
    ##1 tx_code_word_out[anpg_pkg::NP_ACK] == $past(tx_ack_in))
    else $error("outgoing acknowledge bit does not follow arbitration");

  AST_PARTNER_READ: assert property (
    mgmt_rd_in && mgmt_addr_in == anpg_pkg::REG_PARTNER_ABILITY && !rx_page_valid_in
      |-> ##2 mgmt_rdata_out == $past(u_store.mem_q[view_next_q], 2))
    else $error("partner ability read does not show stored page");

  COV_BASE_PAGE: cover property (rx_page_valid_in && !base_done_q);
  COV_NEXT_PAGE: cover property (rx_page_valid_in && base_done_q ##[1:20] tx_page_taken_in);
  COV_FAULT_READ: cover property (par_fault_q && rd_exp ##2 mgmt_rvalid_out);

endmodule

`default_nettype wire

// ### anpg_pkg.sv
/*
  Constants shared by the negotiation page register block: register
  numbers on the management port, field positions and reset values.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package anpg_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register numbers on the management port.
  localparam logic [4:0] REG_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] REG_EXPANSION       = 5'h06;
  localparam logic [4:0] REG_OUTGOING_PAGE   = 5'h07;

  ////////////////////////////////////////////////////////////////////////
  // Partner ability register, base page view.
  localparam int BP_MORE_PAGES   = 15;
  localparam int BP_RECEIPT      = 14;
  localparam int BP_FAULT        = 13;
  localparam int BP_CAP_HI       = 12;
  localparam int BP_CAP_LO       = 5;
  localparam int BP_SEL_HI       = 4;
  localparam int BP_SEL_LO       = 0;
  localparam int CAP_TX_FULL     = 8;
  localparam int CAP_TX_HALF     = 7;
  localparam int CAP_T_FULL      = 6;
  localparam int CAP_T_HALF      = 5;
  localparam logic [4:0] SEL_STANDARD = 5'h01;

  ////////////////////////////////////////////////////////////////////////
  // Next page layout, shared by received and outgoing pages.
  localparam int NP_MORE_PAGES   = 15;
  localparam int NP_ACK          = 14;
  localparam int NP_FORMATTED    = 13;
  localparam int NP_COMPLY       = 12;
  localparam int NP_SYNC         = 11;
  localparam int NP_CODE_HI      = 10;
  localparam int NP_CODE_LO      = 0;
  localparam logic [15:0] OUT_WRITABLE_MASK = 16'hB7FF;

  ////////////////////////////////////////////////////////////////////////
  // Expansion register.
  localparam int EXP_PAR_FAULT   = 4;
  localparam int EXP_LP_NP_ABLE  = 3;
  localparam int EXP_NP_ABLE     = 2;
  localparam int EXP_PAGE_RX     = 1;
  localparam int EXP_LP_ANEG     = 0;

  ////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [15:0] OUT_PAGE_RESET = 16'h0000;
  localparam logic [15:0] PAGE_RESET     = 16'h0000;
  localparam logic        SYNC_RESET     = 1'b0;

endpackage

`default_nettype wire

// ### anpg_page_store.sv
/*
  Two-word store for received link code words: word 0 keeps the base
  page, word 1 the most recent next page. Read data come from a register.
  Assumes one clock and an asynchronous active-high reset.
*/
`default_nettype none

module anpg_page_store
(
  input  wire logic        core_clk_in,    // Core clock.
  input  wire logic        rst_in,         // Asynchronous reset, active high.
  input  wire logic        wr_en_in,       // Write strobe.
  input  wire logic        wr_idx_in,      // Word written.
  input  wire logic [15:0] wr_data_in,     // Word to store.
  input  wire logic        rd_idx_in,      // Word read.
  output logic      [15:0] rd_data_out     // Registered read word.
);

  logic [15:0] mem_q [2];

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mem_q[0] <= anpg_pkg::PAGE_RESET;
      mem_q[1] <= anpg_pkg::PAGE_RESET;
    end
    else if (wr_en_in)
    begin
      mem_q[wr_idx_in] <= wr_data_in;
    end
  end

  // The read is registered so that a write in the same cycle is seen one
  // cycle later, never half-updated.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_data_out <= anpg_pkg::PAGE_RESET;
    end
    else
    begin
      rd_data_out <= mem_q[rd_idx_in];
    end
  end

endmodule

`default_nettype wire

// ### anpg_link_partner.sv
/*
  Behavioural far end of the negotiation link: sends a base page on request
  and answers every outgoing next page after a chosen delay.
  Assumes the page register block on the same clock and reset.
*/
`default_nettype none

module anpg_link_partner
(
  input  wire logic        clk_in,     // Core clock.
  input  wire logic        rst_in,     // Asynchronous reset, active high.
  input  wire logic        start_in,   // Send the base page, pulse.
  input  wire logic [15:0] base_in,    // Base page word.
  input  wire logic [1:0]  lag_in,     // Wait before taking a page.
  input  wire logic        ready_in,   // Outgoing page waiting.
  input  wire logic [15:0] tx_word_in, // Outgoing page word.
  output logic             valid_out,  // Page received, pulse.
  output logic      [15:0] word_out,   // Received code word.
  output logic             take_out,   // Outgoing page taken, pulse.
  output logic             ack_out     // Acknowledge bit of our word.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       tog_q;
  logic [2:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Outside a page the word lines flip every cycle, so a design that
  // samples them without the strobe cannot pass by luck.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      {valid_out, take_out, ack_out, tog_q, cnt_q} <= '0;
      word_out <= 16'h0000;
    end
    else
    begin
      valid_out <= start_in | take_out;
      word_out  <= ~word_out;
      take_out  <= 1'h0;
      cnt_q     <= 3'h0;
      if (start_in)
      begin
        word_out <= base_in;
        tog_q    <= base_in[11];
        ack_out  <= 1'h0;
      end
      else if (take_out)
      begin
        word_out <= {tx_word_in[15], 2'h3, tx_word_in[13], ~tog_q, ~tx_word_in[10:0]};
        tog_q    <= ~tog_q;
      end
      else if (ready_in)
      begin
        cnt_q    <= cnt_q + 3'h1;
        take_out <= cnt_q == {1'h0, lag_in};
        ack_out  <= ack_out | (cnt_q == {1'h0, lag_in});
      end
    end
  end

endmodule

`default_nettype wire

// ### autoneg_page_registers_bench.sv
/*
  Self-checking bench for the page registers: random register traffic
  and link events, compared each cycle with an integer model.
  Assumes the shared package and the link partner model.
*/
`default_nettype none

`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end

module autoneg_page_registers_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk_in = 1'h0;
  logic        rst_in = 1'h1;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'h0;
  logic        wr = 1'h0;
  logic [15:0] wdata = 16'h0000;
  logic        restart = 1'h0;
  logic        pde = 1'h0;
  logic        neg = 1'h0;
  logic        lbs = 1'h0;
  logic        start = 1'h0;
  logic [15:0] base = 16'h0000;
  logic [1:0]  lag = 2'h0;
  logic [15:0] s = 16'h3D41;
  logic [15:0] rdata, txw, rxw, m_base, m_np, m_out, m_txw;
  logic        rvalid, rdy, rxv, take, ack, m_hb, m_hn, m_sync, m_pde, m_prx, m_rdy;
  logic [4:0]  addrs [8] = '{5'h05, 5'h06, 5'h07, 5'h00, 5'h05, 5'h06, 5'h07, 5'h1F};
  int          err_count = 0;
  int          compares = 0;
  int          rq [$];
  int          rv, e, n;

  always #20 core_clk_in = ~core_clk_in;

  anpg_page_regs i_dut
  (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .mgmt_addr_in(addr),
    .mgmt_rd_in(rd),
    .mgmt_wr_in(wr),
    .mgmt_wdata_in(wdata),
    .mgmt_rdata_out(rdata),
    .mgmt_rvalid_out(rvalid),
    .an_restart_in(restart),
    .rx_page_valid_in(rxv),
    .rx_code_word_in(rxw),
    .parallel_detect_error_in(pde),
    .partner_negotiation_capable_in(neg),
    .local_base_sync_in(lbs),
    .tx_ack_in(ack),
    .tx_page_taken_in(take),
    .tx_code_word_out(txw),
    .tx_page_ready_out(rdy)
  );

  anpg_link_partner i_partner
  (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .start_in(start),
    .base_in(base),
    .lag_in(lag),
    .ready_in(rdy),
    .tx_word_in(txw),
    .valid_out(rxv),
    .word_out(rxw),
    .take_out(take),
    .ack_out(ack)
  );

  ////////////////////////////////////////////////////////////////////////
  // Cycle model: sees the inputs the design samples at the same edge.
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      {m_base, m_np, m_out, m_txw} = '0;
      {m_hb, m_hn, m_sync, m_pde, m_prx, m_rdy} = '0;
      rq = '{0, 0};
    end
    else
    begin
      rv = 0;
      // The outgoing word is rebuilt from the state before this edge, so a
      // read of the outgoing page sees the word the design registers here.
      m_txw = (m_out & anpg_pkg::OUT_WRITABLE_MASK) | {1'h0, ack, 2'h0, m_sync, 11'h000};
      if (rd)
        case (addr)
          anpg_pkg::REG_PARTNER_ABILITY: rv = m_hn ? m_np : m_base;
          anpg_pkg::REG_EXPANSION: rv = {11'h000, m_pde, m_base[15], 1'h1, m_prx, neg};
          anpg_pkg::REG_OUTGOING_PAGE: rv = m_txw;
          default: rv = 0;
        endcase
      rq.push_back(rd ? rv | 32'h10000 : 0);
      if (rd && addr == anpg_pkg::REG_EXPANSION)
        {m_pde, m_prx} = 2'h0;
      m_pde = m_pde | pde;
      m_prx = m_prx | rxv;
      // A write in the cycle of a take keeps the page pending.
      if (take)
        m_rdy = 1'h0;
      if (wr && addr == anpg_pkg::REG_OUTGOING_PAGE)
      begin
        m_out = wdata & anpg_pkg::OUT_WRITABLE_MASK;
        m_rdy = 1'h1;
      end
      if (take)
      begin
        m_sync = m_sync ^ m_hb;
      end
      if (rxv && m_hb)
      begin
        m_np = rxw;
        m_hn = 1'h1;
      end
      else if (rxv)
      begin
        m_base = rxw;
        m_hb = 1'h1;
        m_sync = ~lbs;
      end
      if (restart)
        {m_hb, m_hn, m_sync} = 3'h0;
    end
  end

  always @(negedge core_clk_in)
  begin
    e = rq.pop_front();
    `CHK("read valid", e[16], rvalid)
    `CHK("read data", e[15:0], rdata)
    `CHK("outgoing word", m_txw, txw)
    `CHK("page ready", m_rdy, rdy)
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic tick();
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic results();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (2) tick();
    rst_in = 1'h0;
    foreach (addrs[i])
    begin
      addr = addrs[i];
      rd = 1'h1;
      tick();
    end
    rd = 1'h0;
    // A page taken before any base page must leave the sync bit alone.
    addr = anpg_pkg::REG_OUTGOING_PAGE;
    wdata = 16'hFFFF;
    wr = 1'h1;
    tick();
    wr = 1'h0;
    repeat (8) tick();
    for (int r = 0; r < 6; r++)
    begin
      {rd, wr, pde} = 3'h0;
      for (n = 0; n < 50 && rdy; n++) tick();
      if (rdy)
      begin
        err_count++;
        results();
      end
      repeat (4) tick();
      restart = 1'h1;
      tick();
      restart = 1'h0;
      s = lfsr(s);
      base = s;
      lag = s[13:12];
      start = 1'h1;
      tick();
      start = 1'h0;
      repeat (2) tick();
      repeat (300)
      begin
        s = lfsr(s);
        rd = s[1:0] == 2'h1;
        wr = s[1:0] == 2'h2 && !take;
        addr = addrs[s[4:2]];
        wdata = {s[7:0], s[15:8]};
        pde = &s[7:5];
        neg = s[8];
        lbs = s[9];
        tick();
      end
    end
    {rd, wr, pde} = 3'h0;
    repeat (4) tick();
    results();
  end

endmodule

`default_nettype wire
